// ===== rtl/adc_sync_ref_pattern_config.sv
`timescale 1ns/100ps
`default_nettype none
module adc_sync_ref_pattern_config
    import cfg_bank_pkg::*;
#(
    parameter int SAMPLE_W = 14
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                serial_clock_i,
    input  wire logic                serial_enable_n_i,
    input  wire logic                serial_data_i,
    output logic                     serial_data_o,
    output logic                     serial_data_oe_n_o,
    input  wire logic                align_or_powerdown_pin_i,
    input  wire logic [1:0]          vref_buffer_pin_i,
    input  wire logic [7:0]          iface_select_i,
    input  wire logic [SAMPLE_W-1:0] chan_a_sample_i,
    input  wire logic [SAMPLE_W-1:0] chan_b_sample_i,
    output logic                     powerdown_o,
    output logic                     sync_cmd_o,
    output logic [1:0]               vref_select_o,
    output logic                     single_ended_clock_select_o,
    output logic                     diff_clock_buffer_off_o,
    output logic                     chan_a_single_ended_o,
    output logic                     chan_b_single_ended_o,
    output logic [7:0]               bit_mapping_o,
    output logic [SAMPLE_W-1:0]      chan_a_data_o,
    output logic [SAMPLE_W-1:0]      chan_b_data_o
);
    if (SAMPLE_W < 1 || SAMPLE_W > PATTERN_W) begin : g_width_check
        $error("SAMPLE_W must lie between 1 and the pattern width");
    end

    function automatic logic [2:0] reg_index(input logic [6:0] a);
        case (a)
            OFS_SYNC_REF:   reg_index = IDX_SYNC_REF;
            OFS_INPUT_MODE: reg_index = IDX_INPUT_MODE;
            OFS_FUSE_LOAD:  reg_index = IDX_FUSE_LOAD;
            OFS_PAT_LOW:    reg_index = IDX_PAT_LOW;
            OFS_PAT_MID:    reg_index = IDX_PAT_MID;
            OFS_PAT_HIGH:   reg_index = IDX_PAT_HIGH;
            default:        reg_index = IDX_NONE;
        endcase
    endfunction

    logic                wr;
    logic [6:0]          addr;
    logic [7:0]          wdata;
    logic [7:0]          rdata;
    logic [2:0]          idx;
    logic [7:0]          regs_q [NUM_REGS];
    logic [7:0]          regs_d [NUM_REGS];
    logic [7:0]          ctrl;
    logic [PATTERN_W-1:0] pattern_value;
    logic [SAMPLE_W-1:0] pat_top;
    logic [SAMPLE_W-1:0] sample [2];
    logic [SAMPLE_W-1:0] chan_data [2];
    logic [2:0]          pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q, pin_lvl_d;
    logic                pin_prev_q, soft_prev_q, load_prev_q;
    logic                load_fall;
    logic                sync_q, sync_d, pdn_q, pdn_d;
    logic [7:0]          map_q, map_d;

    serial_port_slave u_port (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .sclk_i     (serial_clock_i),
        .sen_n_i    (serial_enable_n_i),
        .sdi_i      (serial_data_i),
        .rdata_i    (rdata),
        .sdo_o      (serial_data_o),
        .sdo_oe_n_o (serial_data_oe_n_o),
        .wr_o       (wr),
        .addr_o     (addr),
        .wdata_o    (wdata)
    );

    assign idx   = reg_index(addr);
    assign rdata = (idx == IDX_NONE) ? 8'h00 : regs_q[idx];
    assign ctrl  = regs_q[IDX_SYNC_REF];
    assign load_fall = load_prev_q & ~regs_q[IDX_FUSE_LOAD][BIT_MAP_LOAD];

    // Register file. A load that completes returns every other register
    // to its reset value; a write landing in that same cycle is lost.
    always_comb begin
        regs_d = regs_q;
        if (load_fall) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                if (i != int'(IDX_FUSE_LOAD)) begin
                    regs_d[i] = REG_RESET;
                end
            end
        end else if (wr && idx != IDX_NONE) begin
            regs_d[idx] = wdata;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= REG_RESET;
            end
        end else begin
            regs_q <= regs_d;
        end
    end

    // Pin inputs: bit 2 is the sync/power-down pin, bits 1:0 the
    // reference pin code.
    always_comb begin
        pin_lvl_d = (pin_s2_q & pin_s3_q)
                  | (pin_lvl_q & (pin_s2_q ^ pin_s3_q));
        pdn_d = pin_lvl_q[2] & ~ctrl[BIT_PIN_SYNC];
        sync_d = 1'b0;
        if (ctrl[BIT_SOFT_EN]) begin
            // Only a 0 to 1 change counts, and the bit never clears itself (a write
            // or a completed load clears it), so the host writes it back to zero first.
            sync_d = ctrl[BIT_SOFT_SYNC] & ~soft_prev_q;
        end else if (ctrl[BIT_PIN_SYNC]) begin
            sync_d = pin_lvl_q[2] & ~pin_prev_q;
        end
        map_d = load_fall ? iface_select_i : map_q;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_s1_q    <= 3'h0;
            pin_s2_q    <= 3'h0;
            pin_s3_q    <= 3'h0;
            pin_lvl_q   <= 3'h0;
            pin_prev_q  <= 1'b0;
            soft_prev_q <= 1'b0;
            load_prev_q <= 1'b0;
            sync_q      <= 1'b0;
            pdn_q       <= 1'b0;
            map_q       <= 8'h00;
        end else begin
            pin_s1_q    <= {align_or_powerdown_pin_i, vref_buffer_pin_i};
            pin_s2_q    <= pin_s1_q;
            pin_s3_q    <= pin_s2_q;
            pin_lvl_q   <= pin_lvl_d;
            pin_prev_q  <= pin_lvl_q[2];
            soft_prev_q <= ctrl[BIT_SOFT_SYNC];
            load_prev_q <= regs_q[IDX_FUSE_LOAD][BIT_MAP_LOAD];
            sync_q      <= sync_d;
            pdn_q       <= pdn_d;
            map_q       <= map_d;
        end
    end

    assign powerdown_o   = pdn_q;
    assign sync_cmd_o    = sync_q;
    assign bit_mapping_o = map_q;
    assign vref_select_o = ctrl[BIT_VREF_OWNER]
                         ? ctrl[BIT_VREF_LSB+:2]
                         : pin_lvl_q[1:0];
    assign single_ended_clock_select_o = ctrl[BIT_VREF_OWNER]
                                       & ctrl[BIT_SE_CLOCK];
    assign diff_clock_buffer_off_o = single_ended_clock_select_o;
    assign chan_a_single_ended_o =
        regs_q[IDX_INPUT_MODE][BIT_CHAN_A_SE];
    assign chan_b_single_ended_o =
        regs_q[IDX_INPUT_MODE][BIT_CHAN_B_SE];

    // The top bits of the pattern value serve as constant and ramp step.
    assign pattern_value = {regs_q[IDX_PAT_HIGH][1:0],
                            regs_q[IDX_PAT_MID],
                            regs_q[IDX_PAT_LOW]};
    assign pat_top = pattern_value[PATTERN_W-1 -: SAMPLE_W];
    assign sample[0] = chan_a_sample_i;
    assign sample[1] = chan_b_sample_i;

    for (genvar g = 0; g < 2; g++) begin : g_chan
        logic [SAMPLE_W-1:0] ramp_q, ramp_d, data_q, data_d;
        pattern_mode_t       mode;
        assign mode = pattern_mode_t'(regs_q[IDX_PAT_HIGH]
                      [(g == 0 ? PAT_A_LSB : PAT_B_LSB) +: 3]);
        always_comb begin
            ramp_d = '0;
            case (mode)
                PAT_RAMP: begin
                    ramp_d = ramp_q + pat_top;
                    data_d = ramp_q;
                end
                PAT_CONST: data_d = pat_top;
                // Unused codes fall back to live data rather than junk.
                default:   data_d = sample[g];
            endcase
        end
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                ramp_q <= '0;
                data_q <= '0;
            end else begin
                ramp_q <= ramp_d;
                data_q <= data_d;
            end
        end
        assign chan_data[g] = data_q;
    end

    assign chan_a_data_o = chan_data[0];
    assign chan_b_data_o = chan_data[1];

    logic [2:0] mode_a;
    assign mode_a = regs_q[IDX_PAT_HIGH][PAT_A_LSB+:3];

    default clocking cb_sys @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_pin_powerdown: assert property (
        pin_lvl_q[2] && !ctrl[BIT_PIN_SYNC] |=> powerdown_o)
        else $error("pin high did not power down");
    a_pin_sync: assert property (
        $rose(pin_lvl_q[2]) && ctrl[BIT_PIN_SYNC] && !ctrl[BIT_SOFT_EN]
        |=> sync_cmd_o ##1 !sync_cmd_o)
        else $error("pin sync pulse wrong");
    a_soft_sync: assert property (
        $rose(ctrl[BIT_SOFT_SYNC]) && ctrl[BIT_SOFT_EN] |=> sync_cmd_o)
        else $error("soft sync not issued");
    a_soft_hold: assert property (
        ctrl[BIT_SOFT_SYNC] && !wr && !load_fall |=> ctrl[BIT_SOFT_SYNC])
        else $error("soft sync bit cleared itself");
    a_pin_masked: assert property (
        ctrl[BIT_SOFT_EN] && !$rose(ctrl[BIT_SOFT_SYNC]) |=> !sync_cmd_o)
        else $error("sync issued without register trigger");
    a_vref_pin: assert property (
        !ctrl[BIT_VREF_OWNER] |-> vref_select_o == pin_lvl_q[1:0]
        && !single_ended_clock_select_o)
        else $error("reference not from pin");
    a_vref_reg: assert property (
        wr && idx == IDX_SYNC_REF && wdata[BIT_VREF_OWNER] && !load_fall
        |=> vref_select_o == $past(wdata[2:1]))
        else $error("reference select not from register");
    a_se_clock: assert property (
        diff_clock_buffer_off_o
        |-> ctrl[BIT_VREF_OWNER] && ctrl[BIT_SE_CLOCK])
        else $error("clock buffer off without control");
    a_chan_input: assert property (
        wr && idx == IDX_INPUT_MODE && !load_fall
        |=> chan_a_single_ended_o == $past(wdata[5])
        && chan_b_single_ended_o == $past(wdata[4]))
        else $error("input mode not applied");
    a_load_reset: assert property (
        load_fall |=> regs_q[IDX_PAT_LOW] == 8'h00 && ctrl == 8'h00
        && bit_mapping_o == $past(iface_select_i))
        else $error("load did not reset registers");
    a_const_pat: assert property (
        mode_a == PAT_CONST |=> chan_a_data_o == $past(pat_top))
        else $error("constant pattern wrong");
    // The step that built the next ramp value is the one of the cycle
    // before, so the consequent compares against the past step.
    a_ramp_step: assert property (
        mode_a == PAT_RAMP && $past(mode_a) == PAT_RAMP && $stable(pat_top)
        |=> chan_a_data_o
        == SAMPLE_W'($past(chan_a_data_o) + $past(pat_top)))
        else $error("ramp step wrong");
    c_soft_sync: cover property (
        sync_cmd_o && ctrl[BIT_SOFT_EN]);
    c_load_done: cover property (
        load_fall);
    c_ramp_run: cover property (
        mode_a == PAT_RAMP [*4]);
endmodule
`default_nettype wire

// ===== rtl/cfg_bank_pkg.sv
`default_nettype none
package cfg_bank_pkg;
    localparam logic [6:0] OFS_SYNC_REF   = 7'h0E;
    localparam logic [6:0] OFS_INPUT_MODE = 7'h11;
    localparam logic [6:0] OFS_FUSE_LOAD  = 7'h13;
    localparam logic [6:0] OFS_PAT_LOW    = 7'h14;
    localparam logic [6:0] OFS_PAT_MID    = 7'h15;
    localparam logic [6:0] OFS_PAT_HIGH   = 7'h16;
    localparam int         NUM_REGS       = 6;
    localparam logic [2:0] IDX_SYNC_REF   = 3'h0;
    localparam logic [2:0] IDX_INPUT_MODE = 3'h1;
    localparam logic [2:0] IDX_FUSE_LOAD  = 3'h2;
    localparam logic [2:0] IDX_PAT_LOW    = 3'h3;
    localparam logic [2:0] IDX_PAT_MID    = 3'h4;
    localparam logic [2:0] IDX_PAT_HIGH   = 3'h5;
    localparam logic [2:0] IDX_NONE       = 3'h7;
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam int         BIT_PIN_SYNC   = 7;
    localparam int         BIT_SOFT_SYNC  = 6;
    localparam int         BIT_SOFT_EN    = 5;
    localparam int         BIT_VREF_OWNER = 3;
    localparam int         BIT_VREF_LSB   = 1;
    localparam int         BIT_SE_CLOCK   = 0;
    localparam int         BIT_CHAN_A_SE  = 5;
    localparam int         BIT_CHAN_B_SE  = 4;
    localparam int         BIT_MAP_LOAD   = 0;
    localparam int         PAT_A_LSB      = 2;
    localparam int         PAT_B_LSB      = 5;
    localparam int         PATTERN_W      = 18;
    localparam logic [4:0] HDR_BITS       = 5'h08;
    localparam logic [4:0] FRAME_BITS     = 5'h10;
    typedef enum logic [2:0] {
        PAT_NORMAL = 3'b000,
        PAT_RAMP   = 3'b010,
        PAT_CONST  = 3'b011
    } pattern_mode_t;
    typedef enum logic [1:0] {
        VREF_INTERNAL = 2'b00,
        VREF_EXT_BUF  = 2'b01,
        VREF_EXTERNAL = 2'b10
    } vref_sel_t;
endpackage
`default_nettype wire

// ===== rtl/serial_port_slave.sv
`timescale 1ns/100ps
`default_nettype none
// Frame: read flag, 7 address bits, 8 data bits, most significant first.
// Pins are sampled, so the serial clock must be well below clk_i / 8.
module serial_port_slave
    import cfg_bank_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       sclk_i,
    input  wire logic       sen_n_i,
    input  wire logic       sdi_i,
    input  wire logic [7:0] rdata_i,
    output logic            sdo_o,
    output logic            sdo_oe_n_o,
    output logic            wr_o,
    output logic [6:0]      addr_o,
    output logic [7:0]      wdata_o
);
    logic [2:0]  s1_q, s2_q, s3_q, lvl_q, lvl_d;
    logic        prev_q;
    logic [15:0] sh_q, sh_d;
    logic [4:0]  cnt_q, cnt_d;
    logic [7:0]  hdr_q, hdr_d, wdata_q, wdata_d;
    logic        sdo_q, sdo_d, oe_n_q, oe_n_d, wr_q, wr_d;
    logic        rise, fall;

    assign rise = lvl_q[2] & ~prev_q;
    assign fall = ~lvl_q[2] & prev_q;

    always_comb begin
        // A pin change counts once the second and third stage agree.
        lvl_d   = (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
        sh_d    = sh_q;
        cnt_d   = cnt_q;
        hdr_d   = hdr_q;
        sdo_d   = sdo_q;
        wdata_d = wdata_q;
        wr_d    = 1'b0;
        oe_n_d  = 1'b1;
        if (lvl_q[1]) begin
            cnt_d = 5'h00;
        end else begin
            oe_n_d = ~(hdr_q[7] & (cnt_q >= HDR_BITS));
            if (rise && cnt_q < FRAME_BITS) begin
                sh_d  = {sh_q[14:0], lvl_q[0]};
                cnt_d = cnt_q + 5'h01;
                if (cnt_q == HDR_BITS - 5'h01) begin
                    hdr_d = sh_d[7:0];
                end
                if (cnt_q == FRAME_BITS - 5'h01 && !sh_d[15]) begin
                    wr_d    = 1'b1;
                    wdata_d = sh_d[7:0];
                end
            end
            if (fall && cnt_q >= HDR_BITS && cnt_q < FRAME_BITS) begin
                sdo_d = rdata_i[~cnt_q[2:0]];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q    <= 3'h2;
            s2_q    <= 3'h2;
            s3_q    <= 3'h2;
            lvl_q   <= 3'h2;
            prev_q  <= 1'b0;
            sh_q    <= 16'h0000;
            cnt_q   <= 5'h00;
            hdr_q   <= 8'h00;
            wdata_q <= 8'h00;
            sdo_q   <= 1'b0;
            oe_n_q  <= 1'b1;
            wr_q    <= 1'b0;
        end else begin
            s1_q    <= {sclk_i, sen_n_i, sdi_i};
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            lvl_q   <= lvl_d;
            prev_q  <= lvl_q[2];
            sh_q    <= sh_d;
            cnt_q   <= cnt_d;
            hdr_q   <= hdr_d;
            wdata_q <= wdata_d;
            sdo_q   <= sdo_d;
            oe_n_q  <= oe_n_d;
            wr_q    <= wr_d;
        end
    end

    assign sdo_o      = sdo_q;
    assign sdo_oe_n_o = oe_n_q;
    assign wr_o       = wr_q;
    assign addr_o     = hdr_q[6:0];
    assign wdata_o    = wdata_q;
endmodule
`default_nettype wire

// ===== verification/cfg_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host on the serial register port: one 16-bit frame per call.
// The phase length can be raised by the bench to act as a slow host.
module cfg_host_model (
    input  wire logic clk_i,
    output logic      sclk_o,
    output logic      sen_n_o,
    output logic      sdi_o,
    input  wire logic sdo_i,
    input  wire logic sdo_oe_n_i
);
    int phase = 6;

    initial begin
        sclk_o = 1'b0;
        sen_n_o = 1'b1;
        sdi_o = 1'b0;
    end

    // The data line wanders between frames, so a stale bit is never read.
    always @(posedge clk_i) begin
        if (sen_n_o) begin
            sdi_o <= ~sdi_o;
        end
    end

    task automatic xfer(input logic rd, input logic [6:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f;
        f = {rd, a, d};
        q = 8'h00;
        @(posedge clk_i);
        sen_n_o <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk_i);
            sdi_o <= f[i];
            repeat (phase) @(posedge clk_i);
            sclk_o <= 1'b1;
            if (i < 8) begin
                q[i] = (sdo_oe_n_i === 1'b0) ? sdo_i : 1'bx;
            end
            repeat (phase) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        repeat (phase) @(posedge clk_i);
        sen_n_o <= 1'b1;
        repeat (phase) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// ===== verification/adc_sync_ref_pattern_config_tb.sv
`timescale 1ns/100ps
`default_nettype none
module adc_sync_ref_pattern_config_tb;
    import cfg_bank_pkg::*;
    localparam int SW = 14;
    localparam logic [6:0] OFS [6] = '{OFS_SYNC_REF, OFS_INPUT_MODE,
        OFS_FUSE_LOAD, OFS_PAT_LOW, OFS_PAT_MID, OFS_PAT_HIGH};
    // Reserved bits, the load bit and the upper reference code bit are kept at zero.
    localparam logic [7:0] MSK [6] = '{8'hEB, 8'h30, 8'h00, 8'hFF,
        8'hFF, 8'hFF};
    logic          clk_i = 1'b0;
    logic          rst_i = 1'b1;
    logic          sclk, sen_n, sdi, sdo, sdo_oe_n;
    logic          pin = 1'b0;
    logic [1:0]    vpin = 2'h0;
    logic [7:0]    iface = 8'h00;
    logic [SW-1:0] smp_a = '0;
    logic [SW-1:0] smp_b = '0;
    logic          pd, sync, se_clk, diff_off, se_a, se_b;
    logic [1:0]    vsel;
    logic [7:0]    map_o;
    logic [SW-1:0] da, db;
    logic [7:0]    mdl [0:127];
    logic [7:0]    exp_map = 8'h00;
    int            exp_syncs = 0;
    int            syncs = 0;
    int            failures = 0;
    int            comparisons = 0;

    initial forever #20 clk_i = ~clk_i;

    adc_sync_ref_pattern_config #(.SAMPLE_W(SW)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .serial_clock_i(sclk),
        .serial_enable_n_i(sen_n), .serial_data_i(sdi),
        .serial_data_o(sdo), .serial_data_oe_n_o(sdo_oe_n),
        .align_or_powerdown_pin_i(pin), .vref_buffer_pin_i(vpin),
        .iface_select_i(iface), .chan_a_sample_i(smp_a),
        .chan_b_sample_i(smp_b), .powerdown_o(pd), .sync_cmd_o(sync),
        .vref_select_o(vsel), .single_ended_clock_select_o(se_clk),
        .diff_clock_buffer_off_o(diff_off), .chan_a_single_ended_o(se_a),
        .chan_b_single_ended_o(se_b), .bit_mapping_o(map_o),
        .chan_a_data_o(da), .chan_b_data_o(db));

    cfg_host_model i_host (.clk_i(clk_i), .sclk_o(sclk), .sen_n_o(sen_n),
        .sdi_o(sdi), .sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n));

    always @(posedge clk_i) begin
        if (sync === 1'b1) begin
            syncs <= syncs + 1;
        end
    end

    task automatic test_done();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s: expected %0h seen %0h", nm, e, s);
        end
    endtask

    task automatic chk_static();
        logic [7:0] c;
        c = mdl[OFS_SYNC_REF];
        check("vref select", c[3] ? c[2:1] : vpin, vsel);
        check("clock select", c[3] & c[0], se_clk);
        check("buffer off", c[3] & c[0], diff_off);
        check("chan a mode", mdl[OFS_INPUT_MODE][5], se_a);
        check("chan b mode", mdl[OFS_INPUT_MODE][4], se_b);
        check("mapping", exp_map, map_o);
        check("sync count", exp_syncs, syncs);
        check("power down", pin & ~c[7], pd);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_host.xfer(1'b0, a, d, q);
        if (a == OFS_SYNC_REF && d[5] && d[6] && !mdl[a][6]) begin
            exp_syncs++;
        end
        if (a == OFS_FUSE_LOAD && mdl[a][0] && !d[0]) begin
            foreach (mdl[k]) mdl[k] = 8'h00;
            exp_map = iface;
        end
        if (a inside {OFS}) begin
            mdl[a] = d;
        end
        chk_static();
    endtask

    task automatic chk_reg(input logic [6:0] a);
        logic [7:0] q;
        i_host.xfer(1'b1, a, 8'h00, q);
        check("register", mdl[a], q);
    endtask

    task automatic set_pin(input logic v, input logic [1:0] vp);
        if (v && !pin && mdl[OFS_SYNC_REF][7] && !mdl[OFS_SYNC_REF][5]) begin
            exp_syncs++;
        end
        @(posedge clk_i);
        pin <= v;
        vpin <= vp;
        repeat (10) @(posedge clk_i);
        chk_static();
    endtask

    task automatic load_map();
        @(posedge clk_i);
        iface <= 8'($urandom);
        wr(OFS_FUSE_LOAD, 8'h01);
        wr(OFS_FUSE_LOAD, 8'h00);
    endtask

    function automatic logic [SW-1:0] pexp(logic [2:0] m, logic [SW-1:0] s,
                                           logic [SW-1:0] o, logic [17:0] p);
        case (m)
            PAT_RAMP: return o + p[17 -: SW];
            PAT_CONST: return p[17 -: SW];
            default: return s;
        endcase
    endfunction

    task automatic chk_pat(input logic [17:0] p);
        logic [SW-1:0] ia, ib, oa, ob;
        wr(OFS_PAT_LOW, p[7:0]);
        wr(OFS_PAT_MID, p[15:8]);
        for (int m = 0; m < 8; m++) begin
            wr(OFS_PAT_HIGH, {3'(7 - m), 3'(m), p[17:16]});
            @(negedge clk_i);
            ia = smp_a;
            ib = smp_b;
            oa = da;
            ob = db;
            @(negedge clk_i);
            check("chan a data", pexp(3'(m), ia, oa, p), da);
            check("chan b data", pexp(3'(7 - m), ib, ob, p), db);
        end
        chk_reg(OFS_PAT_HIGH);
    endtask

    initial begin
        repeat (100000) @(posedge clk_i);
        failures++;
        test_done();
    end

    initial begin
        void'($urandom(32'h225A64D3));
        foreach (mdl[k]) mdl[k] = 8'h00;
        fork
            forever begin
                @(posedge clk_i);
                smp_a <= SW'($urandom);
                smp_b <= SW'($urandom);
            end
        join_none
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        for (int k = 0; k < 6; k++) chk_reg(OFS[k]);
        load_map();
        for (int k = 0; k < 6; k++) wr(OFS[k], 8'($urandom) & MSK[k]);
        wr(7'h21, 8'($urandom));
        i_host.phase = 11;
        for (int k = 0; k < 6; k++) chk_reg(OFS[k]);
        chk_reg(7'h21);
        i_host.phase = 6;
        for (int c = 0; c < 6; c++) begin
            wr(OFS_SYNC_REF, {5'h01, 2'(c >> 1), 1'(c)});
        end
        wr(OFS_SYNC_REF, 8'h00);
        for (int c = 0; c < 3; c++) set_pin(1'b0, 2'(c));
        for (int c = 0; c < 4; c++) begin
            wr(OFS_INPUT_MODE, {2'h0, 2'(c), 4'h0});
        end
        wr(OFS_SYNC_REF, 8'h20);
        wr(OFS_SYNC_REF, 8'h60);
        wr(OFS_SYNC_REF, 8'h60);
        chk_reg(OFS_SYNC_REF);
        wr(OFS_SYNC_REF, 8'h20);
        wr(OFS_SYNC_REF, 8'h40);
        wr(OFS_SYNC_REF, 8'h80);
        set_pin(1'b1, 2'h0);
        set_pin(1'b0, 2'h0);
        wr(OFS_SYNC_REF, 8'hA0);
        set_pin(1'b1, 2'h0);
        set_pin(1'b0, 2'h0);
        wr(OFS_SYNC_REF, 8'h00);
        set_pin(1'b1, 2'h1);
        set_pin(1'b0, 2'h1);
        chk_pat(18'h00010);
        chk_pat(18'($urandom));
        load_map();
        for (int k = 0; k < 6; k++) chk_reg(OFS[k]);
        test_done();
    end
endmodule
`default_nettype wire
